// *** rtl/scp_command_input.sv ***
// Notes on behaviour
// - Three selectable position command pulse patterns.
// - Separate trains: forward port up, reverse down.
// - Pulse inputs are negative logic.
// - Separate trains: idle port on blocks pulses.
// - Pulse plus direction: reverse port gives direction.
// - Quadrature: forward leading means forward movement.
// - Quadrature: reverse leading means reverse movement.
// - Quadrature count multiplied by one, two or four.
// - Position mode discards pulses while inhibit asserted.
// - Speed target is voltage times factor per 10V.
// - Speed direction from sign and run permits.
// - Torque target is voltage times factor per 10V.
// - Torque direction from sign and torque selects.
`timescale 1ns/1ps
`default_nettype none

module scp_command_input
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic forwardPulsePort,
	input wire logic reversePulsePort,
	input wire scp_pkg::scp_pattern_e pulsePatternParam,
	input wire scp_pkg::scp_mult_e quadratureMultiplierParam,
	input wire scp_pkg::scp_mode_e controlModeSelectInput,
	input wire logic pulseInhibit,
	input wire scp_pkg::scp_volt_t speedCommandVoltage,
	input wire scp_pkg::scp_fact_t speedInputFactor,
	input wire logic forwardRunPermit,
	input wire logic reverseRunPermit,
	input wire scp_pkg::scp_volt_t torqueCommandVoltage,
	input wire scp_pkg::scp_fact_t torqueInputFactor,
	input wire logic forwardTorqueSelect,
	input wire logic reverseTorqueSelect,
	output scp_pkg::scp_pos_t positionCommand,
	output logic positionStep,
	output logic positionForward,
	output logic directionSetupViolation,
	output scp_pkg::scp_out_t speedTarget,
	output scp_pkg::scp_out_t torqueTarget
);
	import scp_pkg::*;

	// Signed scaling of a millivolt command by a factor, full scale 10.0 V.
	function automatic scp_out_t scaleCommand(input scp_volt_t volt, input scp_fact_t factor);
		scp_prod_t product;
		scp_prod_t quotient;
		product = volt * $signed({1'b0, factor});
		quotient = product / SCP_FULL_SCALE_MV;
		return quotient[SCP_OUT_W-1:0];
	endfunction

	scp_pulse_if pulses();

	scp_input_sync inputSync
	(
		.clk(clk),
		.rst_b(rst_b),
		.forwardPulsePort(forwardPulsePort),
		.reversePulsePort(reversePulsePort),
		.pulses(pulses)
	);

	logic fwdLevel;
	logic revLevel;
	logic fwdRise;
	logic fwdFall;
	logic revRise;
	logic revFall;
	logic fwdEdge;
	logic revEdge;
	logic positionGate;

	assign fwdLevel = pulses.level[SCP_FWD];
	assign revLevel = pulses.level[SCP_REV];
	assign fwdRise = pulses.rise[SCP_FWD];
	assign fwdFall = pulses.fall[SCP_FWD];
	assign revRise = pulses.rise[SCP_REV];
	assign revFall = pulses.fall[SCP_REV];
	assign fwdEdge = fwdRise | fwdFall;
	assign revEdge = revRise | revFall;
	assign positionGate = (controlModeSelectInput == SCP_MODE_POSITION) && !pulseInhibit;

	logic stepHit;
	logic stepUp;
	logic [SCP_AGE_W-1:0] dirAge;
	logic [SCP_AGE_W-1:0] next_dirAge;
	scp_pos_t next_positionCommand;
	logic next_positionStep;
	logic next_positionForward;
	logic next_directionSetupViolation;

	// In the separate and pulse plus direction patterns a pulse is counted when its line leaves the idle (off) state.
	always_comb
	begin
		stepHit = 1'b0;
		stepUp = 1'b0;
		unique case (pulsePatternParam)
			SCP_PAT_SEPARATE:
			begin
				// An idle port held on means the controller is miswired; pulses are dropped.
				if (fwdFall && revLevel)
				begin
					stepHit = 1'b1;
					stepUp = 1'b1;
				end
				else if (revFall && fwdLevel)
				begin
					stepHit = 1'b1;
				end
			end
			SCP_PAT_PULSE_DIR:
			begin
				stepHit = fwdFall;
				stepUp = revLevel;
			end
			SCP_PAT_QUADRATURE:
			begin
				unique case (quadratureMultiplierParam)
					SCP_MUL_X1:
					begin
						stepHit = fwdRise;
						stepUp = !revLevel;
					end
					SCP_MUL_X2:
					begin
						stepHit = fwdEdge;
						stepUp = fwdLevel != revLevel;
					end
					SCP_MUL_X4:
					begin
						// Simultaneous edges on both phases carry no direction and are dropped.
						stepHit = fwdEdge ^ revEdge;
						stepUp = fwdEdge ? (fwdLevel != revLevel) : (revLevel == fwdLevel);
					end
					default:
					begin
						stepHit = 1'b0;
						stepUp = 1'b0;
					end
				endcase
			end
			default:
			begin
				stepHit = 1'b0;
				stepUp = 1'b0;
			end
		endcase
		stepHit = stepHit && positionGate;

		next_positionCommand = positionCommand;
		if (stepHit)
		begin
			next_positionCommand = stepUp ? positionCommand + SCP_POS_STEP : positionCommand - SCP_POS_STEP;
		end
		next_positionStep = stepHit;
		next_positionForward = stepHit ? stepUp : positionForward;

		// Age of the direction level, used to flag a controller that skips its set-up time.
		next_dirAge = dirAge;
		if (revEdge)
		begin
			next_dirAge = '0;
		end
		else if (dirAge != SCP_DIR_SETUP_CYCLES)
		begin
			next_dirAge = dirAge + SCP_AGE_ONE;
		end
		// A direction edge seen in the same cycle as the pulse counts as zero set-up time.
		next_directionSetupViolation = stepHit && (pulsePatternParam == SCP_PAT_PULSE_DIR)
			&& (revEdge || (dirAge < SCP_DIR_SETUP_CYCLES));
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			positionCommand <= SCP_POS_RESET;
			positionStep <= 1'b0;
			positionForward <= 1'b1;
			dirAge <= SCP_DIR_SETUP_CYCLES;
			directionSetupViolation <= 1'b0;
		end
		else
		begin
			positionCommand <= next_positionCommand;
			positionStep <= next_positionStep;
			positionForward <= next_positionForward;
			dirAge <= next_dirAge;
			directionSetupViolation <= next_directionSetupViolation;
		end
	end

	scp_out_t speedScaled;
	scp_out_t torqueScaled;
	scp_out_t next_speedTarget;
	scp_out_t next_torqueTarget;

	// Outside its own mode each target rests at zero so a mode change never inherits a stale demand.
	always_comb
	begin
		speedScaled = scaleCommand(speedCommandVoltage, speedInputFactor);
		torqueScaled = scaleCommand(torqueCommandVoltage, torqueInputFactor);
		next_speedTarget = SCP_OUT_RESET;
		next_torqueTarget = SCP_OUT_RESET;
		if (controlModeSelectInput == SCP_MODE_SPEED)
		begin
			if ((speedCommandVoltage > 0 && forwardRunPermit) || (speedCommandVoltage < 0 && reverseRunPermit))
			begin
				next_speedTarget = speedScaled;
			end
		end
		if (controlModeSelectInput == SCP_MODE_TORQUE)
		begin
			if (forwardTorqueSelect && !reverseTorqueSelect)
			begin
				next_torqueTarget = torqueScaled;
			end
			else if (reverseTorqueSelect && !forwardTorqueSelect)
			begin
				next_torqueTarget = -torqueScaled;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			speedTarget <= SCP_OUT_RESET;
			torqueTarget <= SCP_OUT_RESET;
		end
		else
		begin
			speedTarget <= next_speedTarget;
			torqueTarget <= next_torqueTarget;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence fwdPinLowHeld;
		(!forwardPulsePort) [*3];
	endsequence

	sequence countedStep;
		positionStep ##0 (positionCommand != $past(positionCommand));
	endsequence

	sync_level_a: assert property (fwdPinLowHeld |-> fwdLevel)
		else $error("Forward pin held low is not read as logic one.");

	sep_forward_a: assert property ((pulsePatternParam == SCP_PAT_SEPARATE) && positionGate && fwdFall && revLevel
		|=> positionCommand == $past(positionCommand) + SCP_POS_STEP)
		else $error("Separate train forward pulse did not count up.");

	sep_reverse_a: assert property ((pulsePatternParam == SCP_PAT_SEPARATE) && positionGate && revFall && fwdLevel
		|=> positionCommand == $past(positionCommand) - SCP_POS_STEP)
		else $error("Separate train reverse pulse did not count down.");

	sep_idle_a: assert property ((pulsePatternParam == SCP_PAT_SEPARATE) && !revLevel && !revFall
		|=> $stable(positionCommand))
		else $error("Pulse counted while idle port is on.");

	dir_reverse_a: assert property ((pulsePatternParam == SCP_PAT_PULSE_DIR) && positionGate && fwdFall && !revLevel
		|=> (positionCommand == $past(positionCommand) - SCP_POS_STEP) && positionStep && !positionForward)
		else $error("Direction level low did not count down.");

	setup_flag_a: assert property ((pulsePatternParam == SCP_PAT_PULSE_DIR) && positionGate && fwdFall && revEdge
		|=> directionSetupViolation)
		else $error("Direction change together with a pulse was not flagged.");

	quad_forward_a: assert property ((pulsePatternParam == SCP_PAT_QUADRATURE) && positionGate
		&& (quadratureMultiplierParam == SCP_MUL_X4) && fwdRise && !revEdge && !revLevel
		|=> positionCommand == $past(positionCommand) + SCP_POS_STEP)
		else $error("Forward leading phase did not count up.");

	quad_reverse_a: assert property ((pulsePatternParam == SCP_PAT_QUADRATURE) && positionGate
		&& (quadratureMultiplierParam == SCP_MUL_X4) && revRise && !fwdEdge && !fwdLevel
		|=> positionCommand == $past(positionCommand) - SCP_POS_STEP)
		else $error("Reverse leading phase did not count down.");

	quad_single_a: assert property ((pulsePatternParam == SCP_PAT_QUADRATURE)
		&& (quadratureMultiplierParam == SCP_MUL_X1) && !fwdRise |=> $stable(positionCommand))
		else $error("Single multiplication counted a non-rising edge.");

	inhibit_hold_a: assert property ((controlModeSelectInput == SCP_MODE_POSITION) && pulseInhibit
		|=> $stable(positionCommand) && !positionStep)
		else $error("Pulse counted while inhibit asserted.");

	step_marks_a: assert property (positionStep |-> countedStep)
		else $error("Step pulse without a counter change.");

	speed_permit_a: assert property ((controlModeSelectInput == SCP_MODE_SPEED) && speedCommandVoltage > 0
		&& !forwardRunPermit |=> speedTarget == SCP_OUT_RESET)
		else $error("Speed target moved without forward permit.");

	torque_reverse_a: assert property ((controlModeSelectInput == SCP_MODE_TORQUE)
		&& reverseTorqueSelect && !forwardTorqueSelect
		|=> torqueTarget == -scaleCommand($past(torqueCommandVoltage), $past(torqueInputFactor)))
		else $error("Reverse torque select did not invert the target.");

endmodule

`default_nettype wire

// *** rtl/scp_input_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module scp_input_sync
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic forwardPulsePort,
	input wire logic reversePulsePort,
	scp_pulse_if.src pulses
);
	import scp_pkg::*;

	logic [1:0] meta;
	logic [1:0] stable;
	logic [1:0] prior;
	logic [1:0] next_meta;
	logic [1:0] next_stable;
	logic [1:0] next_prior;

	// Pins are negative logic: a high pin means the optocoupler is on, read as zero.
	always_comb
	begin
		next_meta = ~{reversePulsePort, forwardPulsePort};
		next_stable = meta;
		next_prior = stable;
	end

	// Reset to the idle level so that an idle line shows no edge after release.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta <= SCP_IDLE_LEVEL;
			stable <= SCP_IDLE_LEVEL;
			prior <= SCP_IDLE_LEVEL;
		end
		else
		begin
			meta <= next_meta;
			stable <= next_stable;
			prior <= next_prior;
		end
	end

	assign pulses.level = stable;
	assign pulses.rise = stable & ~prior;
	assign pulses.fall = ~stable & prior;
endmodule

`default_nettype wire

// *** rtl/scp_pkg.sv ***
package scp_pkg;

	typedef enum logic [1:0] {SCP_PAT_SEPARATE, SCP_PAT_PULSE_DIR, SCP_PAT_QUADRATURE} scp_pattern_e;
	typedef enum logic [1:0] {SCP_MUL_X1, SCP_MUL_X2, SCP_MUL_X4} scp_mult_e;
	typedef enum logic [1:0] {SCP_MODE_POSITION, SCP_MODE_SPEED, SCP_MODE_TORQUE} scp_mode_e;

	localparam int unsigned SCP_POS_W = 32;
	localparam int unsigned SCP_VOLT_W = 16;
	localparam int unsigned SCP_FACT_W = 16;
	localparam int unsigned SCP_OUT_W = 24;
	localparam int unsigned SCP_PROD_W = SCP_VOLT_W + SCP_FACT_W + 1;

	typedef logic signed [SCP_POS_W-1:0] scp_pos_t;
	typedef logic signed [SCP_VOLT_W-1:0] scp_volt_t;
	typedef logic [SCP_FACT_W-1:0] scp_fact_t;
	typedef logic signed [SCP_OUT_W-1:0] scp_out_t;
	typedef logic signed [SCP_PROD_W-1:0] scp_prod_t;

	// Channel indices on the pulse carrier.
	localparam int unsigned SCP_FWD = 0;
	localparam int unsigned SCP_REV = 1;

	// Command voltages are in millivolts; full scale is 10.0 V.
	localparam scp_prod_t SCP_FULL_SCALE_MV = 33'sh2710;

	// Idle optocoupler state is off, which reads as logic one.
	localparam logic [1:0] SCP_IDLE_LEVEL = 2'h3;
	localparam scp_pos_t SCP_POS_RESET = 32'sh0;
	localparam scp_out_t SCP_OUT_RESET = 24'sh0;
	localparam scp_pos_t SCP_POS_STEP = 32'sh1;

	localparam int unsigned SCP_CLK_PERIOD_NS = 10;
	localparam int unsigned SCP_DIR_SETUP_NS = 400;
	localparam int unsigned SCP_AGE_W = 6;
	localparam logic [SCP_AGE_W-1:0] SCP_DIR_SETUP_CYCLES =
		SCP_AGE_W'((SCP_DIR_SETUP_NS + SCP_CLK_PERIOD_NS - 1) / SCP_CLK_PERIOD_NS);
	localparam logic [SCP_AGE_W-1:0] SCP_AGE_ONE = 6'h1;

endpackage

// *** rtl/scp_pulse_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface scp_pulse_if;
	logic [1:0] level;
	logic [1:0] rise;
	logic [1:0] fall;

	modport src
	(
		output level,
		output rise,
		output fall
	);

	modport dst
	(
		input level,
		input rise,
		input fall
	);
endinterface

`default_nettype wire

// *** verif/scp_motion_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module scp_motion_ctrl
import scp_pkg::*;
(
	input wire logic clk,
	output logic fwdPin,
	output logic revPin
);
	// A low pin is an optocoupler that is off, which the driver reads as logic one.
	initial
	begin
		fwdPin = 1'b0;
		revPin = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic setPin(input logic onRev, input logic v);
		if (onRev)
			revPin <= v;
		else
			fwdPin <= v;
	endtask

	// Bad breaks the waveform on purpose: the idle port is left on, or the set-up wait is skipped.
	task automatic send(input scp_pattern_e pat, input logic forward_pulse_port, input int n, input logic bad);
		logic ch;
		ch = (pat == SCP_PAT_SEPARATE) ? !forward_pulse_port : 1'b0;
		if (pat == SCP_PAT_PULSE_DIR)
			revPin <= !forward_pulse_port;
		if (pat == SCP_PAT_PULSE_DIR && !bad)
			hold(50);
		if (pat == SCP_PAT_SEPARATE)
			setPin(forward_pulse_port, bad);
		for (int i = 0; i < n; i++)
		begin
			if (pat == SCP_PAT_QUADRATURE)
			begin
				setPin(!forward_pulse_port, 1'b1);
				hold(125);
				setPin(forward_pulse_port, 1'b1);
				hold(125);
				setPin(!forward_pulse_port, 1'b0);
				hold(125);
				setPin(forward_pulse_port, 1'b0);
				hold(125);
			end
			else
			begin
				setPin(ch, 1'b1);
				hold(50);
				setPin(ch, 1'b0);
				hold(50);
			end
		end
		fwdPin <= 1'b0;
		revPin <= 1'b0;
		hold(50);
	endtask
endmodule

`default_nettype wire

// *** verif/tb_servo_command_pulse_input.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_servo_command_pulse_input;
	import scp_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic fwdPin;
	logic revPin;
	scp_pattern_e pattern = SCP_PAT_SEPARATE;
	scp_mult_e mult = SCP_MUL_X1;
	scp_mode_e mode = SCP_MODE_POSITION;
	logic inhibit = 1'b0;
	scp_volt_t speedV = 16'sh0;
	scp_fact_t speedF = 16'h0;
	scp_volt_t torqueV = 16'sh0;
	scp_fact_t torqueF = 16'h0;
	logic [3:0] bits = 4'h0;
	scp_pos_t positionCommand;
	logic positionStep;
	logic positionForward;
	logic dirViolation;
	scp_out_t speedTarget;
	scp_out_t torqueTarget;
	int mismatches = 0;
	int totalChecks = 0;
	int steps = 0;
	int viols = 0;
	logic [31:0] seed = 32'h4283;
	scp_pos_t expPos = 32'sh0;

	scp_command_input dut (.clk(clk), .rst_b(rst_b), .forwardPulsePort(fwdPin), .reversePulsePort(revPin),
		.pulsePatternParam(pattern), .quadratureMultiplierParam(mult), .controlModeSelectInput(mode),
		.pulseInhibit(inhibit), .speedCommandVoltage(speedV), .speedInputFactor(speedF),
		.forwardRunPermit(bits[0]), .reverseRunPermit(bits[1]), .torqueCommandVoltage(torqueV),
		.torqueInputFactor(torqueF), .forwardTorqueSelect(bits[2]), .reverseTorqueSelect(bits[3]),
		.positionCommand(positionCommand), .positionStep(positionStep), .positionForward(positionForward),
		.directionSetupViolation(dirViolation), .speedTarget(speedTarget), .torqueTarget(torqueTarget));
	scp_motion_ctrl ctrl (.clk(clk), .fwdPin(fwdPin), .revPin(revPin));

	initial
	begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (positionStep === 1'b1)
			steps++;
		if (dirViolation === 1'b1)
			viols++;
	end

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic scp_out_t scale(scp_volt_t v, scp_fact_t f, logic ok, logic neg);
		longint p;
		p = longint'(v) * longint'(f) / 10000;
		if (!ok)
			p = 0;
		if (neg)
			p = -p;
		return scp_out_t'(p);
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic burst(input int i);
		logic forward_pulse_port;
		logic bad;
		int n;
		int k;
		int d;
		@(posedge clk);
		pattern <= (i == 9) ? scp_pattern_e'(3) : scp_pattern_e'(i % 3);
		mult <= scp_mult_e'((i / 3) % 4);
		mode <= (i >= 9 && rnd() % 6 == 0) ? SCP_MODE_SPEED : SCP_MODE_POSITION;
		inhibit <= (i == 3) || (i >= 9 && rnd() % 4 == 0);
		forward_pulse_port = (i == 1) ? 1'b0 : 1'(rnd());
		bad = (i < 2) || (rnd() % 4 == 0);
		n = 1 + int'(rnd() % 3);
		repeat (4) @(posedge clk);
		steps = 0;
		viols = 0;
		ctrl.send(pattern, forward_pulse_port, n, bad);
		k = (pattern != SCP_PAT_QUADRATURE) ? 1 : (mult == SCP_MUL_X1) ? 1 : (mult == SCP_MUL_X2) ? 2
			: (mult == SCP_MUL_X4) ? 4 : 0;
		d = forward_pulse_port ? n * k : -n * k;
		if (mode != SCP_MODE_POSITION || inhibit || (pattern == SCP_PAT_SEPARATE && bad)
			|| (pattern > SCP_PAT_QUADRATURE))
			d = 0;
		repeat (5) @(posedge clk);
		#1;
		expPos = expPos + d;
		check(positionCommand, expPos);
		check(steps, (d < 0) ? -d : d);
		if (d != 0)
			check(positionForward, forward_pulse_port);
		check(viols != 0, pattern == SCP_PAT_PULSE_DIR && bad && !forward_pulse_port && d != 0);
		$display("test %0d done", i);
	endtask

	task automatic analog(input int i);
		scp_mode_e m;
		scp_volt_t sv;
		scp_volt_t tv;
		scp_fact_t sf;
		scp_fact_t tf;
		logic [3:0] b;
		m = scp_mode_e'((i + 1) % 4);
		sv = (i == 0) ? 16'sh2710 : scp_volt_t'(int'(rnd() % 20001) - 10000);
		tv = (i == 1) ? -16'sh2710 : scp_volt_t'(int'(rnd() % 20001) - 10000);
		sf = (i < 2) ? 16'hffff : 16'(rnd());
		tf = (i < 2) ? 16'hffff : 16'(rnd());
		b = (i < 2) ? 4'h5 : 4'(rnd());
		@(posedge clk);
		mode <= m;
		speedV <= sv;
		torqueV <= tv;
		speedF <= sf;
		torqueF <= tf;
		bits <= b;
		repeat (2) @(posedge clk);
		#1;
		check(speedTarget, scale(sv, sf, m == SCP_MODE_SPEED && ((sv > 0 && b[0]) || (sv < 0 && b[1])), 1'b0));
		check(torqueTarget, scale(tv, tf, m == SCP_MODE_TORQUE && (b[2] ^ b[3]), b[3]));
		$display("test %0d done", 100 + i);
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		mismatches++;
		print_verdict();
	end

	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(positionCommand, SCP_POS_RESET);
		check(positionForward, 1'b1);
		for (int i = 0; i < 18; i++)
			burst(i);
		// A reset in mid-run must bring the count and direction back to their reset values.
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		expPos = SCP_POS_RESET;
		check(positionCommand, expPos);
		check(positionForward, 1'b1);
		$display("test %0d done", 50);
		for (int i = 0; i < 15; i++)
			analog(i);
		print_verdict();
	end
endmodule

`default_nettype wire
